// [logic/cpr_pkg.sv]
package cpr_pkg;

  // channel count and field widths
  localparam int NUM_CH = 4;
  localparam int MODE_W = 2;
  localparam int SRC_W = 2;

  // run mode encodings
  typedef enum logic [MODE_W-1:0] {
    CPR_MODE_CONT = 2'h0,
    CPR_MODE_TRIG = 2'h1,
    CPR_MODE_TRIG_CONT = 2'h2,
    CPR_MODE_GATED = 2'h3
  } cpr_mode_t;

  // trigger source encodings; 2'h3 is unused and treated as no source
  typedef enum logic [SRC_W-1:0] {
    CPR_SRC_A = 2'h0,
    CPR_SRC_B = 2'h1,
    CPR_SRC_INT = 2'h2,
    CPR_SRC_NONE = 2'h3
  } cpr_src_t;

  // per-channel playout settings, carried as one word
  typedef struct packed {
    cpr_mode_t mode;
    cpr_src_t src;
  } cpr_cfg_t;

  // reset values
  localparam cpr_cfg_t CFG_RST = '{mode: CPR_MODE_CONT, src: CPR_SRC_A};
  localparam logic EN_RST = 1'h0;
  localparam logic RUN_RST = 1'h0;
  localparam logic GLOBAL_RST = 1'h0;

endpackage

// [logic/cpr_trig_sel.sv]
module cpr_trig_sel (
  input wire cpr_pkg::cpr_cfg_t cfg,
  input wire logic a_rise,
  input wire logic b_rise,
  input wire logic a_lvl,
  input wire logic b_lvl,
  input wire logic int_pulse,
  input wire logic force_a,
  input wire logic force_b,
  output logic trig_evt,
  output logic gate_lvl
);

  ////////////////////////////////////////////////////////////////////////
  // source decode
  wire logic sel_a;
  wire logic sel_b;
  wire logic sel_int;
  wire logic is_cont;
  wire logic is_gated;

  assign is_cont = (cfg.mode == cpr_pkg::CPR_MODE_CONT);
  assign is_gated = (cfg.mode == cpr_pkg::CPR_MODE_GATED);
  assign sel_a = !is_cont && (cfg.src == cpr_pkg::CPR_SRC_A);
  assign sel_b = !is_cont && (cfg.src == cpr_pkg::CPR_SRC_B);
  assign sel_int = !is_cont && !is_gated && (cfg.src == cpr_pkg::CPR_SRC_INT);

  ////////////////////////////////////////////////////////////////////////
  // event and gate outputs
  wire logic ev_a;
  wire logic ev_b;

  assign ev_a = sel_a && (a_rise || force_a);
  assign ev_b = sel_b && (b_rise || force_b);
  assign trig_evt = ev_a || ev_b || (sel_int && int_pulse);
  // level of the chosen external input; low for any other setting
  assign gate_lvl = is_gated && ((sel_a && a_lvl) || (sel_b && b_lvl));

endmodule

// [logic/cpr_chan_fsm.sv]
module cpr_chan_fsm (
  input wire logic clk,
  input wire logic rst_b,
  input wire cpr_pkg::cpr_mode_t mode,
  input wire logic run,
  input wire logic trig_evt,
  input wire logic gate_lvl,
  input wire logic wave_end,
  output logic playout
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_ONE,
    ST_CONT,
    ST_GATE
  } cpr_state_t;

  cpr_state_t state_reg;
  cpr_state_t state_next;
  logic playout_reg;
  logic playout_next;

  ////////////////////////////////////////////////////////////////////////
  // next state; dropping run always returns to idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run) begin
          case (mode)
            cpr_pkg::CPR_MODE_CONT: state_next = ST_CONT;
            cpr_pkg::CPR_MODE_GATED: state_next = ST_GATE;
            default: state_next = ST_ARMED;
          endcase
        end
      end
      ST_ARMED: begin
        if (!run) begin
          state_next = ST_IDLE;
        end else if (trig_evt) begin
          if (mode == cpr_pkg::CPR_MODE_TRIG_CONT) begin
            state_next = ST_CONT;
          end else begin
            state_next = ST_ONE;
          end
        end
      end
      ST_ONE: begin
        if (!run) begin
          state_next = ST_IDLE;
        end else if (wave_end) begin
          state_next = ST_ARMED;
        end
      end
      ST_CONT: begin
        if (!run) begin
          state_next = ST_IDLE;
        end
      end
      ST_GATE: begin
        if (!run) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  assign playout_next = (state_next == ST_ONE) ||
                        (state_next == ST_CONT) ||
                        ((state_next == ST_GATE) && gate_lvl);

  // state and registered playout level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      playout_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      playout_reg <= playout_next;
    end
  end

  assign playout = playout_reg;

endmodule

// [logic/cpr_run_ctrl.sv]
module cpr_run_ctrl #(
  parameter int NUM_CH = cpr_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire cpr_pkg::cpr_cfg_t [NUM_CH-1:0] cfg_wdata,
  input wire logic [NUM_CH-1:0] cfg_wr,
  input wire logic [NUM_CH-1:0] sync_mask,
  input wire logic [NUM_CH-1:0] seq_assigned,
  input wire logic [NUM_CH-1:0] res_valid,
  input wire logic [NUM_CH-1:0] play_req,
  input wire logic [NUM_CH-1:0] stop_req,
  input wire logic [NUM_CH-1:0] ch_on_req,
  input wire logic [NUM_CH-1:0] ch_off_req,
  input wire logic global_on_req,
  input wire logic global_off_req,
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic int_trig,
  input wire logic force_a_req,
  input wire logic force_b_req,
  input wire logic [NUM_CH-1:0] wave_end,
  output cpr_pkg::cpr_cfg_t [NUM_CH-1:0] cfg_rdata,
  output logic [NUM_CH-1:0] cfg_reject,
  output logic [NUM_CH-1:0] playout,
  output logic [NUM_CH-1:0] run_state,
  output logic [NUM_CH-1:0] out_connect,
  output logic [NUM_CH-1:0] conn_led,
  output logic knob_led,
  output logic global_en
);

  ////////////////////////////////////////////////////////////////////////
  // external trigger edge detection, shared by all channels

  logic trig_a_reg;
  logic trig_b_reg;
  wire logic a_rise;
  wire logic b_rise;

  // previous level; inputs are already in this clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_a_reg <= 1'h0;
      trig_b_reg <= 1'h0;
    end else begin
      trig_a_reg <= trig_a;
      trig_b_reg <= trig_b;
    end
  end

  assign a_rise = trig_a && !trig_a_reg;
  assign b_rise = trig_b && !trig_b_reg;

  ////////////////////////////////////////////////////////////////////////
  // settings write with sync coupling

  // a write to any synced channel reaches every synced channel
  wire logic [NUM_CH-1:0] sync_wr;
  wire logic any_sync_wr;
  cpr_pkg::cpr_cfg_t sync_data;

  assign sync_wr = cfg_wr & sync_mask;
  assign any_sync_wr = |sync_wr;

  // lowest written synced channel wins when several write at once
  always_comb begin
    sync_data = cpr_pkg::CFG_RST;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (sync_wr[k]) begin
        sync_data = cfg_wdata[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel settings, enable, run state and playout

  // global indication: set by global on, cleared by any off request
  wire logic any_off;
  wire logic global_next;
  logic global_reg;
  logic knob_reg;

  assign any_off = |ch_off_req;
  assign global_next = (global_on_req && !any_off && !global_off_req) ? 1'h1
                     : (any_off || global_off_req) ? 1'h0
                     : global_reg;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      wire logic own_wr;
      wire logic do_wr;
      cpr_pkg::cpr_cfg_t wr_data;
      wire logic bad_combo;
      wire logic wr_ok;
      cpr_pkg::cpr_cfg_t cfg_reg;
      cpr_pkg::cpr_cfg_t cfg_next;
      logic reject_reg;
      cpr_pkg::cpr_cfg_t cfg_eff;
      logic run_reg;
      wire logic run_next;
      logic en_reg;
      wire logic en_next;
      wire logic run_ok;
      wire logic evt;
      wire logic gate;

      // synced channels take the shared word
      assign own_wr = cfg_wr[i] && !sync_mask[i];
      assign do_wr = own_wr || (sync_mask[i] && any_sync_wr);
      assign wr_data = own_wr ? cfg_wdata[i] : sync_data;

      assign bad_combo = (wr_data.mode == cpr_pkg::CPR_MODE_GATED) &&
                         (wr_data.src == cpr_pkg::CPR_SRC_INT);
      assign wr_ok = do_wr && !bad_combo;
      assign cfg_next = wr_ok ? wr_data : cfg_reg;

      // settings register and one-cycle refusal pulse
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_reg <= cpr_pkg::CFG_RST;
          reject_reg <= 1'h0;
        end else begin
          cfg_reg <= cfg_next;
          reject_reg <= do_wr && bad_combo;
        end
      end

      always_comb begin
        cfg_eff = cfg_reg;
        if (seq_assigned[i]) begin
          cfg_eff.mode = cpr_pkg::CPR_MODE_CONT;
        end
      end

      assign run_ok = run_reg && res_valid[i];

      // playing/stopped per channel
      // play beats stop in the same cycle; invalid resource forces stop
      assign run_next = !res_valid[i] ? 1'h0
                      : play_req[i] ? 1'h1
                      : stop_req[i] ? 1'h0
                      : run_reg;

      // global on sets all
      // off requests win so the global flag and the channels stay in step
      assign en_next = (ch_off_req[i] || global_off_req) ? 1'h0
                     : (ch_on_req[i] || global_on_req) ? 1'h1
                     : en_reg;

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          run_reg <= cpr_pkg::RUN_RST;
          en_reg <= cpr_pkg::EN_RST;
        end else begin
          run_reg <= run_next;
          en_reg <= en_next;
        end
      end

      cpr_trig_sel u_trig (
        .cfg(cfg_eff),
        .a_rise(a_rise),
        .b_rise(b_rise),
        .a_lvl(trig_a),
        .b_lvl(trig_b),
        .int_pulse(int_trig),
        .force_a(force_a_req),
        .force_b(force_b_req),
        .trig_evt(evt),
        .gate_lvl(gate)
      );

      // playout ignores enable
      // position keeps moving while off, so enabling resumes mid-waveform
      cpr_chan_fsm u_fsm (
        .clk(clk),
        .rst_b(rst_b),
        .mode(cfg_eff.mode),
        .run(run_ok),
        .trig_evt(evt),
        .gate_lvl(gate),
        .wave_end(wave_end[i]),
        .playout(playout[i])
      );

      assign cfg_rdata[i] = cfg_reg;
      assign cfg_reject[i] = reject_reg;
      assign run_state[i] = run_reg;
      assign out_connect[i] = en_reg;
      assign conn_led[i] = en_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // global flag and knob lighting

  wire logic knob_next;

  assign knob_next = |out_connect_next_vec(ch_off_req, global_off_req,
                                           ch_on_req, global_on_req,
                                           out_connect);

  // next enable vector, same priority as the per-channel enables
  function automatic logic [NUM_CH-1:0] out_connect_next_vec(
    input logic [NUM_CH-1:0] offs,
    input logic goff,
    input logic [NUM_CH-1:0] ons,
    input logic gon,
    input logic [NUM_CH-1:0] cur
  );
    logic [NUM_CH-1:0] r;
    r = cur;
    for (int k = 0; k < NUM_CH; k++) begin
      if (offs[k] || goff) begin
        r[k] = 1'h0;
      end else if (ons[k] || gon) begin
        r[k] = 1'h1;
      end
    end
    return r;
  endfunction

  // registered so the lamp changes with the channel enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_reg <= cpr_pkg::GLOBAL_RST;
      knob_reg <= 1'h0;
    end else begin
      global_reg <= global_next;
      knob_reg <= knob_next;
    end
  end

  assign global_en = global_reg;
  assign knob_led = knob_reg;

endmodule

// [verif/cpr_run_ctrl_asserts.sv]
module cpr_run_ctrl_asserts #(
  parameter int NUM_CH = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire cpr_pkg::cpr_cfg_t [NUM_CH-1:0] cfg_wdata,
  input wire logic [NUM_CH-1:0] cfg_wr,
  input wire logic [NUM_CH-1:0] sync_mask,
  input wire logic [NUM_CH-1:0] res_valid,
  input wire logic [NUM_CH-1:0] play_req,
  input wire logic [NUM_CH-1:0] ch_off_req,
  input wire logic global_on_req,
  input wire logic global_off_req,
  input wire cpr_pkg::cpr_cfg_t [NUM_CH-1:0] cfg_rdata,
  input wire logic [NUM_CH-1:0] cfg_reject,
  input wire logic [NUM_CH-1:0] playout,
  input wire logic [NUM_CH-1:0] run_state,
  input wire logic [NUM_CH-1:0] out_connect,
  input wire logic [NUM_CH-1:0] conn_led,
  input wire logic knob_led,
  input wire logic global_en
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam cpr_pkg::cpr_cfg_t BAD =
    '{mode: cpr_pkg::CPR_MODE_GATED, src: cpr_pkg::CPR_SRC_INT};
  logic [NUM_CH-1:0] play_ok_reg;

  // taken play requests; invalid ones are masked since they are refused
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      play_ok_reg <= '0;
    end else begin
      play_ok_reg <= play_req & res_valid;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////
  led_follow_a: assert property (conn_led == out_connect)
    else $error("connector led differs from enable");
  knob_any_a: assert property (knob_led == (|out_connect))
    else $error("knob light wrong");
  global_all_a: assert property (global_on_req && !global_off_req &&
    ch_off_req == 0 |=> global_en && (&out_connect))
    else $error("global on did not enable all");
  off_clears_a: assert property (ch_off_req != 0 |=> !global_en &&
    (out_connect & $past(ch_off_req)) == 0)
    else $error("channel off not honoured");
  global_sub_a: assert property (global_en |-> &out_connect)
    else $error("global flag with a channel off");
  play_take_a: assert property (play_ok_reg != 0 |->
    (run_state & play_ok_reg) == play_ok_reg)
    else $error("play request not taken");
  invalid_stop_a: assert property (res_valid != '1 |=>
    (run_state & ~$past(res_valid)) == 0)
    else $error("invalid channel running");
  idle_quiet_a: assert property (
    (playout & ~run_state & ~$past(run_state)) == 0)
    else $error("playout while stopped");
  reject_gate_a: assert property (cfg_wr[0] && cfg_wdata[0] == BAD &&
    sync_mask == 0 |=> cfg_reject[0])
    else $error("gated internal not refused");
  keep_cfg_a: assert property (cfg_wr[1] && cfg_wdata[1] != BAD &&
    sync_mask == 0 |=> cfg_rdata[1] == $past(cfg_wdata[1]))
    else $error("setting not stored");
endmodule

bind cpr_run_ctrl cpr_run_ctrl_asserts #(.NUM_CH(NUM_CH)) chk_inst (
  .clk(clk), .rst_b(rst_b), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
  .sync_mask(sync_mask), .res_valid(res_valid), .play_req(play_req),
  .ch_off_req(ch_off_req), .global_on_req(global_on_req),
  .global_off_req(global_off_req), .cfg_rdata(cfg_rdata),
  .cfg_reject(cfg_reject), .playout(playout), .run_state(run_state),
  .out_connect(out_connect), .conn_led(conn_led), .knob_led(knob_led),
  .global_en(global_en)
);

// [verif/cpr_trig_gen.sv]
module cpr_trig_gen (
  input wire logic clk,
  output logic trig_a,
  output logic trig_b,
  output logic int_trig,
  output logic force_a_req,
  output logic force_b_req
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  // quiet trigger pins until told otherwise
  initial begin
    trig_a = 0;
    trig_b = 0;
    {int_trig, force_a_req, force_b_req} = 3'h0;
  end
  // input a rises, holds a few cycles so the level is seen, then falls
  task automatic edge_a();
    @(posedge clk);
    #2 trig_a = 1;
    repeat (3) @(posedge clk);
    #2 trig_a = 0;
  endtask
  // gate level on input b
  task automatic lvl_b(logic v);
    @(posedge clk);
    #2 trig_b = v;
  endtask
  // one-cycle pulse: 0 internal, 1 force a, 2 force b
  task automatic fire(int w);
    @(posedge clk);
    #2 {force_b_req, force_a_req, int_trig} = 3'(1 << w);
    @(posedge clk);
    #2 {force_b_req, force_a_req, int_trig} = 3'h0;
  endtask
endmodule

// [verif/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = cpr_pkg::NUM_CH;
  logic clk = 0;
  logic rst_b = 0;
  cpr_pkg::cpr_cfg_t [N-1:0] wd = '0, rd, mdl;
  logic [N-1:0] wr = 0, sm = 0, sq = 0, rv = '1, pl = 0, st = 0;
  logic [N-1:0] on = 0, off = 0, we = 0, rej, po, rs, oc, cl;
  logic gon = 0, goff = 0, kl, ge;
  logic trig_a, trig_b, int_trig, force_a_req, force_b_req;
  int fails = 0, n_compared = 0, cyc = 0, i;
  int unsigned rnd;

  cpr_run_ctrl cpr_run_ctrl_inst (.clk(clk), .rst_b(rst_b),
    .cfg_wdata(wd), .cfg_wr(wr), .sync_mask(sm), .seq_assigned(sq),
    .res_valid(rv), .play_req(pl), .stop_req(st), .ch_on_req(on),
    .ch_off_req(off), .global_on_req(gon), .global_off_req(goff),
    .trig_a(trig_a), .trig_b(trig_b), .int_trig(int_trig),
    .force_a_req(force_a_req), .force_b_req(force_b_req),
    .wave_end(we), .cfg_rdata(rd), .cfg_reject(rej), .playout(po),
    .run_state(rs), .out_connect(oc), .conn_led(cl), .knob_led(kl),
    .global_en(ge));
  cpr_trig_gen tg (.clk(clk), .trig_a(trig_a), .trig_b(trig_b),
    .int_trig(int_trig), .force_a_req(force_a_req),
    .force_b_req(force_b_req));

  ////////////////////////////////////////
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // drives land 2 ns after the edge, away from sampling
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // refused combination keeps the old setting
  function automatic cpr_pkg::cpr_cfg_t after_wr(cpr_pkg::cpr_cfg_t o,
                                                 cpr_pkg::cpr_cfg_t n);
    if (n.mode == cpr_pkg::CPR_MODE_GATED && n.src == cpr_pkg::CPR_SRC_INT)
      return o;
    return n;
  endfunction
  // one write, reject pulse checked while it stands, then a quiet cycle
  task automatic cfg(int c, cpr_pkg::cpr_mode_t md, cpr_pkg::cpr_src_t s);
    logic bad;
    bad = (md == cpr_pkg::CPR_MODE_GATED) && (s == cpr_pkg::CPR_SRC_INT);
    wd[c] = '{mode: md, src: s};
    mdl[c] = after_wr(mdl[c], wd[c]);
    wr[c] = 1;
    step(1);
    chk(rej[c], bad, "reject pulse");
    wr = 0;
    step(1);
  endtask
  // bounded wait for a playout level, a few cycles at most
  task automatic wpo(int c, logic v, string m);
    for (int k = 0; k < 4 && po[c] !== v; k++) step(1);
    chk(po[c], v, m);
  endtask
  task automatic wend(int c);
    we[c] = 1;
    step(1);
    we = 0;
  endtask

  initial begin
    rnd = $urandom(2080);
    mdl = {N{cpr_pkg::CFG_RST}};
    step(8);
    rst_b = 1;
    step(1);
    chk(rd, mdl, "reset cfg");
    chk({oc, rs, po, kl, ge}, 16'h0000, "reset outputs");
    gon = 1;
    step(1);
    gon = 0;
    chk({oc, cl, kl, ge}, 16'h03ff, "global on");
    off[2] = 1;
    step(1);
    off = 0;
    chk({oc, cl, kl, ge}, 16'h02ee, "one off");
    off = '1;
    step(1);
    off = 0;
    chk({oc, kl}, 16'h0000, "all off");
    cfg(0, cpr_pkg::CPR_MODE_GATED, cpr_pkg::CPR_SRC_INT);
    chk(rd, mdl, "gated internal");
    repeat (6) begin
      i = $urandom_range(N - 1, 0);
      cfg(i, cpr_pkg::cpr_mode_t'($urandom_range(3, 0)),
          cpr_pkg::cpr_src_t'($urandom_range(3, 0)));
      chk(rd, mdl, "random cfg");
    end
    sm = 4'h3;
    cfg(1, cpr_pkg::CPR_MODE_TRIG, cpr_pkg::CPR_SRC_A);
    mdl[0] = mdl[1];
    chk(rd, mdl, "synced cfg");
    sm = 0;
    cfg(0, cpr_pkg::CPR_MODE_CONT, cpr_pkg::CPR_SRC_INT);
    cfg(2, cpr_pkg::CPR_MODE_TRIG_CONT, cpr_pkg::CPR_SRC_INT);
    cfg(3, cpr_pkg::CPR_MODE_GATED, cpr_pkg::CPR_SRC_B);
    pl = '1;
    step(1);
    pl = 0;
    chk(rs, 16'h000f, "run state");
    step(1);
    chk(po, 16'h0001, "cont starts alone");
    wend(0);
    step(1);
    chk({oc[0], po[0]}, 16'h0001, "repeat while off");
    tg.edge_a();
    wpo(1, 1, "trig plays");
    tg.edge_a();
    wend(1);
    wpo(1, 0, "retrig ignored");
    step(3);
    chk(po[1], 0, "waits after cycle");
    tg.fire(2);
    step(2);
    chk(po[1], 0, "force b unarmed");
    tg.fire(1);
    wpo(1, 1, "force a");
    wend(1);
    wpo(1, 0, "force cycle ends");
    tg.fire(0);
    wpo(2, 1, "internal start");
    wend(2);
    step(2);
    chk(po[2], 1, "keeps running");
    st[2] = 1;
    step(1);
    st = 0;
    chk(rs[2], 0, "stop");
    wpo(2, 0, "stop ends");
    tg.lvl_b(1);
    wpo(3, 1, "gate high");
    tg.lvl_b(0);
    wpo(3, 0, "gate low");
    rv[0] = 0;
    pl[0] = 1;
    step(1);
    pl = 0;
    chk(rs[0], 0, "invalid refused");
    wpo(0, 0, "invalid blocked");
    rv = '1;
    sq[1] = 1;
    st[1] = 1;
    step(1);
    st = 0;
    pl[1] = 1;
    step(1);
    pl = 0;
    wpo(1, 1, "sequence plays");
    report_and_stop();
  end
endmodule
